/* File: sim/haptic_tracking_trim_regs_tb_top.sv */
`timescale 1ns/1ps
module haptic_tracking_trim_regs_tb_top
  import haptic_trim_pkg::*;
();
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic converter_clip_in = 0, actuator_flag_clear = 0, tracking_enable_in = 0;
  logic tracking_error_large = 0, drive_reversal = 0, e;
  logic pready, pslverr, phase_delay_freeze, gain_autoscale, tracking_keep_active;
  logic tracking_run, loop_dac_wide_range, loop_narrow_band, delay_comparator_bypass;
  logic hold_update_on_reversal, freq_update_enable, conversion_offset_enable;
  logic converter_clip_event, converter_clip_state, converter_clip_mask, converter_clip_alert;
  logic [7:0] phase_delay_coarse;
  logic [2:0] phase_delay_shift;
  logic [1:0] undervoltage_level, loop_capacitor_adjust, loop_resistor_adjust;
  logic [1:0] low_side_slew, high_side_slew;
  int fail_count = 0;
  int n_tests = 0;
  int j;
  logic [7:0] dv [6];
  logic [7:0] sd [100];
  logic [7:0] ri [12] = '{IDX_PHASE_HIGH, IDX_PHASE_LOW, IDX_TRACK_CTL, IDX_THRESH_TRIM,
    IDX_FILTER_TRIM, IDX_SLEW_TRIM, IDX_MISC_CFG, IDX_FAULT_EVENT, IDX_STATUS_TWO,
    IDX_MASK_TWO, IDX_SNIP_FIRST, IDX_SNIP_LAST};
  logic [7:0] rv [12] = '{8'h25, 8'h05, 8'h00, 8'h08, 8'h0c, 8'h0f, 8'h03, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00};
  logic [7:0] wi [6] = '{IDX_TRACK_CTL, IDX_THRESH_TRIM, IDX_FILTER_TRIM, IDX_SLEW_TRIM,
    IDX_MISC_CFG, IDX_MASK_TWO};
  logic [7:0] wm [6] = '{WMASK_TRACK_CTL, WMASK_THRESH_TRIM, WMASK_FILTER_TRIM,
    WMASK_SLEW_TRIM, WMASK_MISC_CFG, 8'h80};

  haptic_tracking_trim_regs dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .converter_clip_in, .actuator_flag_clear,
    .tracking_enable_in, .tracking_error_large, .drive_reversal, .phase_delay_coarse,
    .phase_delay_freeze, .phase_delay_shift, .gain_autoscale, .tracking_keep_active,
    .tracking_run, .loop_dac_wide_range, .loop_narrow_band, .undervoltage_level,
    .loop_capacitor_adjust, .loop_resistor_adjust, .low_side_slew, .high_side_slew,
    .delay_comparator_bypass, .hold_update_on_reversal, .freq_update_enable,
    .conversion_offset_enable, .converter_clip_event, .converter_clip_state,
    .converter_clip_mask, .converter_clip_alert);

  // 40 MHz clock
  always #12.5 pclk = ~pclk;

  // ----
  // Tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  // One transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16)
      chk("pready", 0, 1);
  endtask : apb

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, {2'b00, i, 2'b00}, d);
  endtask : wr

  task automatic rd(input string nm, input logic [7:0] i, input logic [7:0] x);
    apb(1'b0, {2'b00, i, 2'b00}, 8'h00);
    chk(nm, r, {24'h0, x});
  endtask : rd

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  // ----
  // Tests
  // ----
  initial
  begin
    void'($urandom(2));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 12; k++)
      rd("reset", ri[k], rv[k]);
    chk("rst", {conversion_offset_enable, loop_capacitor_adjust, low_side_slew}, 5'h1f);
    $display("test reset done");
    // random writes, unwritable bits read 0
    for (int k = 0; k < 18; k++)
    begin
      j = k % 6;
      dv[j] = 8'($urandom);
      wr(wi[j], dv[j]);
      rd("rw", wi[j], dv[j] & wm[j]);
    end
    chk("trk", {gain_autoscale, tracking_keep_active}, dv[0][1:0]);
    chk("loop_threshold_trim", {loop_dac_wide_range, loop_narrow_band, undervoltage_level}, dv[1][6:3]);
    chk("loop_filter_trim", {loop_capacitor_adjust, loop_resistor_adjust}, dv[2][3:0]);
    chk("bridge_slew_trim", {low_side_slew, high_side_slew}, dv[3][3:0]);
    chk("misc", {delay_comparator_bypass, hold_update_on_reversal,
      conversion_offset_enable}, dv[4][2:0]);
    chk("mask", converter_clip_mask, dv[5][7]);
    $display("test readback done");
    wr(IDX_PHASE_HIGH, 8'h00);
    rd("ph_h", IDX_PHASE_HIGH, 8'h00);
    wr(IDX_PHASE_HIGH, 8'h26);
    rd("ph_h", IDX_PHASE_HIGH, 8'h00);
    wr(IDX_PHASE_LOW, 8'h02);
    rd("ph_l", IDX_PHASE_LOW, 8'h05);
    // Freeze only with wideband codes and tracking idle
    wr(IDX_PHASE_LOW, 8'h80);
    rd("ph_l", IDX_PHASE_LOW, 8'h80);
    chk("frz", phase_delay_freeze, 1);
    chk("phase_out", {phase_delay_coarse, phase_delay_shift}, 11'h000);
    $display("test phase done");
    for (int k = 0; k < 100; k++)
    begin
      sd[k] = 8'($urandom);
      wr(IDX_SNIP_FIRST + 8'(k), sd[k]);
    end
    for (int k = 0; k < 100; k++)
      rd("snip", IDX_SNIP_FIRST + 8'(k), sd[k]);
    apb(1'b0, 12'h3a0, 8'h00);
    chk("past_end", e, 1);
    chk("err_data", r, 0);
    // Misaligned write aims at byte 0 and must not land
    apb(1'b1, 12'h211, ~sd[0]);
    chk("misalign", e, 1);
    rd("snip0", IDX_SNIP_FIRST, sd[0]);
    wr(IDX_FAULT_EVENT, 8'hff);
    rd("ev_ro", IDX_FAULT_EVENT, 8'h00);
    $display("test snippet done");
    wr(IDX_MASK_TWO, 8'h00);
    converter_clip_in <= 1'b1;
    @(posedge pclk);
    converter_clip_in <= 1'b0;
    rd("ev", IDX_FAULT_EVENT, 8'h04);
    chk("alert", converter_clip_alert, 1);
    rd("st", IDX_STATUS_TWO, 8'h00);
    converter_clip_in <= 1'b1;
    rd("st", IDX_STATUS_TWO, 8'h80);
    converter_clip_in <= 1'b0;
    wr(IDX_MASK_TWO, 8'h80);
    rd("ev", IDX_FAULT_EVENT, 8'h04);
    chk("masked", converter_clip_alert, 0);
    // Clip and clear in one cycle: the set must win
    {converter_clip_in, actuator_flag_clear} <= 2'b11;
    @(posedge pclk);
    converter_clip_in <= 1'b0;
    @(posedge pclk);
    chk("set_wins", converter_clip_event, 1);
    actuator_flag_clear <= 1'b0;
    rd("ev_clr", IDX_FAULT_EVENT, 8'h00);
    $display("test fault done");
    {tracking_enable_in, tracking_error_large, drive_reversal} <= 3'b111;
    wr(IDX_TRACK_CTL, 8'h01);
    wr(IDX_MISC_CFG, 8'h02);
    repeat (2) @(posedge pclk);
    chk("run", {tracking_run, freq_update_enable}, 2'b10);
    wr(IDX_TRACK_CTL, 8'h00);
    wr(IDX_MISC_CFG, 8'h00);
    repeat (2) @(posedge pclk);
    chk("run", {tracking_run, freq_update_enable}, 2'b01);
    wr(IDX_MISC_CFG, 8'h02);
    repeat (200)
    begin
      @(posedge pclk);
      {tracking_enable_in, tracking_error_large, drive_reversal} <= 3'($urandom);
    end
    $display("test tracking done");
    wrap_up();
  end

  // Watchdog well beyond the expected run
  initial
  begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    wrap_up();
  end
endmodule : haptic_tracking_trim_regs_tb_top

bind haptic_tracking_trim_regs haptic_trim_assertions chk_u (.pclk, .presetn, .psel,
  .penable, .paddr, .pready, .pslverr, .converter_clip_in, .actuator_flag_clear,
  .tracking_enable_in, .tracking_error_large, .drive_reversal, .phase_delay_coarse,
  .phase_delay_shift, .tracking_keep_active, .tracking_run, .hold_update_on_reversal,
  .freq_update_enable, .converter_clip_event, .converter_clip_state, .converter_clip_mask,
  .converter_clip_alert);

/* File: sim/haptic_trim_assertions.sv */
`timescale 1ns/1ps
module haptic_trim_assertions
  import haptic_trim_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic converter_clip_in,
  input wire logic actuator_flag_clear,
  input wire logic tracking_enable_in,
  input wire logic tracking_error_large,
  input wire logic drive_reversal,
  input wire logic [7:0] phase_delay_coarse,
  input wire logic [2:0] phase_delay_shift,
  input wire logic tracking_keep_active,
  input wire logic tracking_run,
  input wire logic hold_update_on_reversal,
  input wire logic freq_update_enable,
  input wire logic converter_clip_event,
  input wire logic converter_clip_state,
  input wire logic converter_clip_mask,
  input wire logic converter_clip_alert
);
  // ----
  // Checks
  // ----
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Wait-free slave: access cycle always answered
  a_ready_timely:
    assert property (psel && !penable |=> pready) else $error("late ready");
  a_phase_legal:
    assert property (phase_delay_coarse inside {8'h25, 8'h00}) else $error("bad phase");
  a_shift_legal:
    assert property (phase_delay_shift inside {3'h5, 3'h0}) else $error("bad shift");
  // Guarded by the past reset so the first edge is not judged
  a_track_keep:
    assert property ($past(presetn) |-> tracking_run == $past(tracking_enable_in
      && (!tracking_error_large || tracking_keep_active))) else $error("bad run");
  a_hold_reversal:
    assert property ($past(presetn) |-> freq_update_enable ==
      !$past(hold_update_on_reversal && drive_reversal)) else $error("bad hold");
  a_clip_sets:
    assert property (converter_clip_in |=> converter_clip_event) else $error("no event");
  a_clip_clears:
    assert property (!converter_clip_in && actuator_flag_clear |=> !converter_clip_event)
      else $error("event stuck");
  a_state_follows:
    assert property ($past(presetn) |-> converter_clip_state == $past(converter_clip_in))
      else $error("bad state");
  a_mask_quiets:
    assert property (converter_clip_mask |=> !converter_clip_alert) else $error("alert");
  a_alert_raised:
    assert property (!converter_clip_mask && converter_clip_event |=> converter_clip_alert)
      else $error("no alert");
  a_snip_bound:
    assert property (psel && !penable && paddr == 12'h3a0 |=> pslverr) else $error("no err");
endmodule : haptic_trim_assertions

/* File: src/haptic_tracking_trim_regs.sv */
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module haptic_tracking_trim_regs
  import haptic_trim_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic converter_clip_in,
  input wire logic actuator_flag_clear,
  input wire logic tracking_enable_in,
  input wire logic tracking_error_large,
  input wire logic drive_reversal,
  output logic [7:0] phase_delay_coarse,
  output logic phase_delay_freeze,
  output logic [2:0] phase_delay_shift,
  output logic gain_autoscale,
  output logic tracking_keep_active,
  output logic tracking_run,
  output logic loop_dac_wide_range,
  output logic loop_narrow_band,
  output logic [1:0] undervoltage_level,
  output logic [1:0] loop_capacitor_adjust,
  output logic [1:0] loop_resistor_adjust,
  output logic [1:0] low_side_slew,
  output logic [1:0] high_side_slew,
  output logic delay_comparator_bypass,
  output logic hold_update_on_reversal,
  output logic freq_update_enable,
  output logic conversion_offset_enable,
  output logic converter_clip_event,
  output logic converter_clip_state,
  output logic converter_clip_mask,
  output logic converter_clip_alert
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] phase_high_q;
  logic freeze_q;
  logic [2:0] shift_q;
  logic [7:0] track_ctl_q;
  logic [7:0] thresh_trim_q;
  logic [7:0] filter_trim_q;
  logic [7:0] slew_trim_q;
  logic [7:0] misc_cfg_q;
  logic clip_event_q;
  logic clip_state_q;
  logic [7:0] mask_two_q;
  logic tracking_run_q;
  logic freq_update_q;
  logic clip_alert_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic [7:0] idx;
  logic word_ok;
  logic in_snip;
  logic mapped;
  logic setup_ph;
  logic commit_wr;
  logic [7:0] wbyte;
  logic [6:0] snip_addr;
  logic [7:0] snip_rdata;
  logic [7:0] rd_byte;

  // Index of a mapped byte register, or not mapped
  function automatic logic is_mapped(input logic [7:0] i);
    case (i)
      IDX_PHASE_HIGH, IDX_PHASE_LOW, IDX_TRACK_CTL,
      IDX_THRESH_TRIM, IDX_FILTER_TRIM, IDX_SLEW_TRIM,
      IDX_MISC_CFG, IDX_FAULT_EVENT, IDX_STATUS_TWO,
      IDX_MASK_TWO: is_mapped = 1'b1;
      default: is_mapped = (i >= IDX_SNIP_FIRST) && (i <= IDX_SNIP_LAST);
    endcase
  endfunction : is_mapped

  // Writes through writable bits only, rest read zero
  function automatic logic [7:0] merge_w(input logic [7:0] d,
                                         input logic [7:0] m);
    merge_w = d & m;
  endfunction : merge_w

  // Word aligned, upper bits of the byte address must be zero
  assign idx = paddr[9:2];
  assign word_ok = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  assign in_snip = (idx >= IDX_SNIP_FIRST) && (idx <= IDX_SNIP_LAST);
  assign mapped = word_ok && is_mapped(idx);
  assign setup_ph = psel && !penable;
  assign wbyte = pwdata[7:0];

  // Write lands only at the sampled completion edge
  assign commit_wr = psel && penable && pwrite && pready_q && !pslverr_q;

  // consecutive indices map to consecutive bytes
  assign snip_addr = 7'(idx - IDX_SNIP_FIRST);

  // ----------------------------------------
  // Snippet memory
  // ----------------------------------------
  // hundred bytes, range checked by decode
  snippet_store #(
    .DEPTH(SNIP_DEPTH),
    .AW(7)
  ) u_snip (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(commit_wr && in_snip),
    .addr(snip_addr),
    .wr_data(wbyte),
    .rd_data(snip_rdata)
  );

  // ----------------------------------------
  // APB handshake
  // ----------------------------------------
  // One wait-free access phase: ready rises for the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= setup_ph;
      pslverr_q <= setup_ph && !mapped;
    end
  end

  // Read data captured in setup, one transfer in flight at a time
  always_comb
  begin
    rd_byte = 8'h00;
    case (idx)
      IDX_PHASE_HIGH: rd_byte = phase_high_q;
      IDX_PHASE_LOW: rd_byte = {freeze_q, 4'h0, shift_q};
      IDX_TRACK_CTL: rd_byte = track_ctl_q;
      IDX_THRESH_TRIM: rd_byte = thresh_trim_q;
      IDX_FILTER_TRIM: rd_byte = filter_trim_q;
      IDX_SLEW_TRIM: rd_byte = slew_trim_q;
      IDX_MISC_CFG: rd_byte = misc_cfg_q;
      IDX_FAULT_EVENT: rd_byte = 8'(clip_event_q) << POS_CLIP_EVENT;
      IDX_STATUS_TWO: rd_byte = 8'(clip_state_q) << POS_CLIP_STATE;
      IDX_MASK_TWO: rd_byte = mask_two_q;
      default: rd_byte = in_snip ? snip_rdata : 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
    end
    else if (setup_ph && !pwrite && mapped)
    begin
      prdata_q <= {24'h00_0000, rd_byte};
    end
    else if (setup_ph)
    begin
      prdata_q <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Phase delay settings
  // ----------------------------------------
  // Reserved codes are dropped so hardware never sees them
  // coarse phase only 0x25 or 0x00
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_high_q <= RST_PHASE_HIGH;
    end
    else if (commit_wr && idx == IDX_PHASE_HIGH &&
             (wbyte == RST_PHASE_HIGH || wbyte == PHASE_HIGH_WIDE))
    begin
      phase_high_q <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      freeze_q <= 1'b0;
      shift_q <= RST_PHASE_SHIFT;
    end
    else if (commit_wr && idx == IDX_PHASE_LOW)
    begin
      // freeze stored as written, software keeps it legal
      freeze_q <= wbyte[POS_FREEZE];
      if (wbyte[2:0] == RST_PHASE_SHIFT || wbyte[2:0] == SHIFT_WIDE)
      begin
        shift_q <= wbyte[2:0];
      end
    end
  end

  // ----------------------------------------
  // Plain control and trim registers
  // ----------------------------------------
  // autoscale and keep-active control bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      track_ctl_q <= RST_TRACK_CTL;
    end
    else if (commit_wr && idx == IDX_TRACK_CTL)
    begin
      track_ctl_q <= merge_w(wbyte, WMASK_TRACK_CTL);
    end
  end

  // undervoltage level resets to code 01
  // wide DAC range and narrow loop band
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      thresh_trim_q <= RST_THRESH_TRIM;
    end
    else if (commit_wr && idx == IDX_THRESH_TRIM)
    begin
      thresh_trim_q <= merge_w(wbyte, WMASK_THRESH_TRIM);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      filter_trim_q <= RST_FILTER_TRIM;
    end
    else if (commit_wr && idx == IDX_FILTER_TRIM)
    begin
      filter_trim_q <= merge_w(wbyte, WMASK_FILTER_TRIM);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slew_trim_q <= RST_SLEW_TRIM;
    end
    else if (commit_wr && idx == IDX_SLEW_TRIM)
    begin
      slew_trim_q <= merge_w(wbyte, WMASK_SLEW_TRIM);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      misc_cfg_q <= RST_MISC_CFG;
    end
    else if (commit_wr && idx == IDX_MISC_CFG)
    begin
      misc_cfg_q <= merge_w(wbyte, WMASK_MISC_CFG);
    end
  end

  // clip mask, only bit 7 writable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask_two_q <= RST_MASK_TWO;
    end
    else if (commit_wr && idx == IDX_MASK_TWO)
    begin
      mask_two_q <= 8'(wbyte[POS_CLIP_MASK]) << POS_CLIP_MASK;
    end
  end

  // ----------------------------------------
  // Saturation fault
  // ----------------------------------------
  // Set beats clear so a clip in the clearing cycle survives
  // sticky event, cleared by actuator_flag_clear input
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clip_event_q <= 1'b0;
    end
    else if (converter_clip_in)
    begin
      clip_event_q <= 1'b1;
    end
    else if (actuator_flag_clear)
    begin
      clip_event_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clip_state_q <= 1'b0;
      clip_alert_q <= 1'b0;
    end
    else
    begin
      clip_state_q <= converter_clip_in;
      clip_alert_q <= (clip_event_q || converter_clip_in) &&
                      !mask_two_q[POS_CLIP_MASK];
    end
  end

  // ----------------------------------------
  // Tracking qualifiers
  // ----------------------------------------
  // Large error stops tracking unless keep-active is set
  // keep tracking despite large error
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tracking_run_q <= 1'b0;
      freq_update_q <= 1'b0;
    end
    else
    begin
      tracking_run_q <= tracking_enable_in &&
        (!tracking_error_large || track_ctl_q[POS_KEEP_ACTIVE]);
      freq_update_q <= !(misc_cfg_q[POS_HOLD_REV] && drive_reversal);
    end
  end

  // ----------------------------------------
  // Outputs, all from flops
  // ----------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign phase_delay_coarse = phase_high_q;
  assign phase_delay_freeze = freeze_q;
  assign phase_delay_shift = shift_q;
  // autoscale enable to the tracking loop
  assign gain_autoscale = track_ctl_q[POS_AUTOSCALE];
  assign tracking_keep_active = track_ctl_q[POS_KEEP_ACTIVE];
  assign tracking_run = tracking_run_q;
  assign loop_dac_wide_range = thresh_trim_q[POS_WIDE_RANGE];
  assign loop_narrow_band = thresh_trim_q[POS_NARROW_BAND];
  assign undervoltage_level = thresh_trim_q[POS_UV_LO +: 2];
  assign loop_capacitor_adjust = filter_trim_q[POS_CAP_LO +: 2];
  assign loop_resistor_adjust = filter_trim_q[1:0];
  assign low_side_slew = slew_trim_q[POS_LS_LO +: 2];
  assign high_side_slew = slew_trim_q[1:0];
  assign delay_comparator_bypass = misc_cfg_q[POS_BYPASS];
  assign hold_update_on_reversal = misc_cfg_q[POS_HOLD_REV];
  assign freq_update_enable = freq_update_q;
  assign conversion_offset_enable = misc_cfg_q[POS_OFFSET_EN];
  assign converter_clip_event = clip_event_q;
  assign converter_clip_state = clip_state_q;
  assign converter_clip_mask = mask_two_q[POS_CLIP_MASK];
  assign converter_clip_alert = clip_alert_q;

endmodule : haptic_tracking_trim_regs

/* File: src/haptic_trim_pkg.sv */
package haptic_trim_pkg;

  // ----------------------------------------
  // Register indices (byte address = 4 x index)
  // ----------------------------------------
  localparam logic [7:0] IDX_PHASE_HIGH = 8'h48;
  localparam logic [7:0] IDX_PHASE_LOW = 8'h49;
  localparam logic [7:0] IDX_TRACK_CTL = 8'h4c;
  localparam logic [7:0] IDX_THRESH_TRIM = 8'h5f;
  localparam logic [7:0] IDX_FILTER_TRIM = 8'h60;
  localparam logic [7:0] IDX_SLEW_TRIM = 8'h62;
  localparam logic [7:0] IDX_MISC_CFG = 8'h6e;
  localparam logic [7:0] IDX_FAULT_EVENT = 8'h81;
  localparam logic [7:0] IDX_STATUS_TWO = 8'h82;
  localparam logic [7:0] IDX_MASK_TWO = 8'h83;
  localparam logic [7:0] IDX_SNIP_FIRST = 8'h84;
  localparam logic [7:0] IDX_SNIP_LAST = 8'he7;
  localparam int SNIP_DEPTH = 100;

  // ----------------------------------------
  // Reset values and writable bits
  // ----------------------------------------
  localparam logic [7:0] RST_PHASE_HIGH = 8'h25;
  localparam logic [7:0] PHASE_HIGH_WIDE = 8'h00;
  localparam logic [2:0] RST_PHASE_SHIFT = 3'h5;
  localparam logic [2:0] SHIFT_WIDE = 3'h0;
  localparam logic [7:0] RST_TRACK_CTL = 8'h00;
  localparam logic [7:0] WMASK_TRACK_CTL = 8'h03;
  localparam logic [7:0] RST_THRESH_TRIM = 8'h08;
  localparam logic [7:0] WMASK_THRESH_TRIM = 8'h7f;
  localparam logic [7:0] RST_FILTER_TRIM = 8'h0c;
  localparam logic [7:0] WMASK_FILTER_TRIM = 8'h0f;
  localparam logic [7:0] RST_SLEW_TRIM = 8'h0f;
  localparam logic [7:0] WMASK_SLEW_TRIM = 8'h0f;
  localparam logic [7:0] RST_MISC_CFG = 8'h03;
  localparam logic [7:0] WMASK_MISC_CFG = 8'h07;
  localparam logic [7:0] RST_MASK_TWO = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int POS_FREEZE = 7;
  localparam int POS_AUTOSCALE = 1;
  localparam int POS_KEEP_ACTIVE = 0;
  localparam int POS_WIDE_RANGE = 6;
  localparam int POS_NARROW_BAND = 5;
  localparam int POS_UV_LO = 3;
  localparam int POS_CAP_LO = 2;
  localparam int POS_LS_LO = 2;
  localparam int POS_BYPASS = 2;
  localparam int POS_HOLD_REV = 1;
  localparam int POS_OFFSET_EN = 0;
  localparam int POS_CLIP_EVENT = 2;
  localparam int POS_CLIP_STATE = 7;
  localparam int POS_CLIP_MASK = 7;

endpackage : haptic_trim_pkg

/* File: src/snippet_store.sv */
`timescale 1ns/1ps
module snippet_store
  import haptic_trim_pkg::*;
#(
  parameter int DEPTH = SNIP_DEPTH,
  parameter int AW = 7
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data
);

  // ----------------------------------------
  // Byte array
  // ----------------------------------------
  logic [7:0] mem_q [DEPTH];

  // Flops rather than RAM, so every byte clears on reset
  // bytes clear on reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_q[i] <= 8'h00;
      end
    end
    else if (wr_en && (int'(addr) < DEPTH))
    begin
      mem_q[addr] <= wr_data;
    end
  end

  // Out-of-range index reads zero
  always_comb
  begin
    rd_data = 8'h00;
    if (int'(addr) < DEPTH)
    begin
      rd_data = mem_q[addr];
    end
  end

endmodule : snippet_store
